// [hdl/irq_pkg.sv]
// Shared constants, register map and decode function for the interrupt block
package irq_pkg;

  // Source numbering, which is also the default rank order (0 is highest)
  localparam int NUM_SRC = 7;
  localparam logic [2:0] SRC_BASIC = 3'h0;
  localparam logic [2:0] SRC_EXT4 = 3'h1;
  localparam logic [2:0] SRC_EXT0 = 3'h2;
  localparam logic [2:0] SRC_EXT1 = 3'h3;
  localparam logic [2:0] SRC_TMR0 = 3'h4;
  localparam logic [2:0] SRC_TMR1 = 3'h5;
  localparam logic [2:0] SRC_WATCH = 3'h6;

  // Register indices; byte address is four times the index
  localparam logic [11:0] PRIORITY_IDX = 12'hFB2;
  localparam logic [11:0] WATCH_FLAGS_IDX = 12'hFBA;
  localparam logic [11:0] TMR1_FLAGS_IDX = 12'hFBB;
  localparam logic [11:0] CTRL_IDX = 12'hFC0;
  localparam logic [11:0] EVT_STATUS_IDX = 12'hFC1;
  localparam logic [11:0] EVT_MASK_IDX = 12'hFC2;
  localparam logic [11:0] SERVICE_VIEW_IDX = 12'hFC3;

  // Field positions
  localparam int FLAG_REQ_BIT = 0;
  localparam int FLAG_EN_BIT = 1;
  localparam int MASTER_EN_BIT = 3;
  localparam int CTRL_WATCH_SEL_BIT = 0;
  localparam int EVT_TMR1_BIT = 0;
  localparam int EVT_WATCH_BIT = 1;
  localparam int EVT_TAKE_BIT = 2;

  // Reset values
  localparam logic [3:0] PRIORITY_RESET = 4'h0;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [2:0] EVT_RESET = 3'h0;

  // Service status field codes
  localparam logic [1:0] SVC_ALL = 2'h0;
  localparam logic [1:0] SVC_FAVOURED = 2'h1;
  localparam logic [1:0] SVC_NONE = 2'h2;

  // Timing: clock 20 ns; intervals rounded down to whole cycles
  localparam int CLOCK_NS = 20;
  localparam int WATCH_LONG_NS = 500_000_000;
  localparam int WATCH_SHORT_NS = 3_190_000;
  localparam int WATCH_LONG_CYCLES = WATCH_LONG_NS / CLOCK_NS;
  localparam int WATCH_SHORT_CYCLES = WATCH_SHORT_NS / CLOCK_NS;
  localparam logic [1:0] TAKE_HOLDOFF = 2'h2;

  // Priority code to favoured source mask
  function automatic logic [6:0] favour_mask(input logic [2:0] code);
    case (code)
      3'h1: favour_mask = 7'h03;
      3'h2: favour_mask = 7'h04;
      3'h3: favour_mask = 7'h08;
      3'h5: favour_mask = 7'h10;
      3'h6: favour_mask = 7'h20;
      default: favour_mask = 7'h00;
    endcase
  endfunction : favour_mask

endpackage : irq_pkg

// [hdl/arb_if.sv]
// Carrier between the controller and its arbiter
`timescale 1ns/1ps
interface arb_if;
  logic [6:0] pend;
  logic [6:0] elig;
  logic [6:0] favour;
  logic fifo_mode;
  logic pick_valid;
  logic [2:0] pick;
  modport arb (input pend, elig, favour, fifo_mode,
               output pick_valid, pick);
  modport ctl (output pend, elig, favour, fifo_mode,
               input pick_valid, pick);
endinterface : arb_if

// [hdl/irq_arbiter.sv]
// Arrival-order and rank arbiter over the seven request sources
`timescale 1ns/1ps
module irq_arbiter (
  input wire logic clk,
  input wire logic rst,
  arb_if.arb bus
);
  logic [6:0] pend_prev;
  logic [6:0] arrive;
  logic [6:0] older [7];
  logic [6:0] oldest;
  logic [6:0] fav_elig;
  logic [6:0] cand;
  logic [2:0] pick_idx;

  // Remember which requests were already waiting
  always_ff @(posedge clk) begin
    if (rst) pend_prev <= 7'h00;
    else pend_prev <= bus.pend;
  end
  assign arrive = bus.pend & ~pend_prev;

  // older[i][j]: i arrived strictly before j; same-cycle arrivals stay tied
  for (genvar i = 0; i < 7; i++) begin : g_row
    for (genvar j = 0; j < 7; j++) begin : g_col
      always_ff @(posedge clk) begin
        if (rst || !bus.pend[i] || !bus.pend[j]) begin
          older[i][j] <= 1'b0;
        end else if (arrive[j] && !arrive[i]) begin
          older[i][j] <= 1'b1; // RL7
        end
      end
    end
    // A source is oldest when no eligible source is older than it
    assign oldest[i] = bus.elig[i] &&
      ((bus.elig & {older[6][i], older[5][i], older[4][i], older[3][i],
                    older[2][i], older[1][i], older[0][i]}) == 7'h00);
  end

  // Favoured source first, then arrival order or plain rank
  assign fav_elig = bus.elig & bus.favour;
  assign cand = (fav_elig != 7'h00) ? fav_elig : // RL10
                (bus.fifo_mode ? oldest : bus.elig); // RL7 RL8

  // Lowest index wins among candidates, which is the default rank
  always_comb begin
    pick_idx = 3'h0;
    for (int k = 6; k >= 0; k--) begin
      if (cand[k]) pick_idx = 3'(k); // RL9
    end
  end
  assign bus.pick = pick_idx;
  assign bus.pick_valid = (bus.elig != 7'h00);

  // No eligible source of better rank among the candidates
  a_rank_order: assert property (@(posedge clk) disable iff (rst) // RL9
    bus.pick_valid |-> ((cand & ((7'h01 << bus.pick) - 7'h01)) == 7'h00)
                       && cand[bus.pick])
    else $error("arbiter picked a source below a better-ranked one");

  // In arrival mode nothing eligible is older than the pick
  a_arrival_order: assert property (@(posedge clk) disable iff (rst) // RL7
    (bus.pick_valid && bus.fifo_mode && fav_elig == 7'h00)
      |-> oldest[bus.pick])
    else $error("arbiter passed over an earlier request");

endmodule : irq_arbiter

// [hdl/irq_flags_priority.sv]
// Interrupt flags, priority register and service grant with AHB-Lite access
//
// Functional notes
// RL1 - Timer 1 match requests pass on only while the timer 1 enable is set.
// RL2 - Timer 1 request sets on counter/reference match, clears when taken.
// RL3 - Watch request sets at each 0.5 s or 3.19 ms interval, as selected.
// RL4 - The watch request is never cleared by hardware; software clears it.
// RL5 - Master enable low blocks all servicing, high allows it.
// RL6 - The 3-bit priority code chooses the favoured source, 000 none.
// RL7 - With code 000, waiting requests are served in arrival order.
// RL8 - Requests arriving together are resolved by the default ranking.
// RL9 - Ranking: basic timer and pin 4, pin 0, pin 1, timer 0, timer 1.
// RL10 - The favoured source wins contention, then default ranking resumes.
// RL11 - Software may use the priority code to single out one source.
// RL12 - Service status 00 serves all, 01 only the favoured, 10 none.
// RL13 - A request set while disabled stays pending until enabled.
`timescale 1ns/1ps
module irq_flags_priority #(
  parameter int TIMER_WIDTH = 8,
  parameter int WATCH_LONG_CYCLES = irq_pkg::WATCH_LONG_CYCLES,
  parameter int WATCH_SHORT_CYCLES = irq_pkg::WATCH_SHORT_CYCLES
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic SYS_RST_IN,
  // AHB-Lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // Timer 1 compare inputs
  input wire logic [TIMER_WIDTH-1:0] TIMER1_COUNTER_IN,
  input wire logic [TIMER_WIDTH-1:0] TIMER1_REFERENCE_IN,
  // Enabled request levels of the other sources
  input wire logic BASIC_TIMER_IRQ_IN,
  input wire logic EXT_PIN4_IRQ_IN,
  input wire logic EXT_PIN0_IRQ_IN,
  input wire logic EXT_PIN1_IRQ_IN,
  input wire logic TIMER0_MATCH_IRQ_IN,
  // CPU service side
  input wire logic [1:0] SERVICE_STATUS_FIELD_IN,
  input wire logic SERVICE_TAKE_IN,
  output logic IRQ_REQ_OUT,
  output logic [2:0] IRQ_SOURCE_OUT,
  output logic [6:0] SOURCE_ACK_OUT,
  // Event interrupt
  output logic IRQ_OUT
);

  localparam int WCNT_W = $clog2(WATCH_LONG_CYCLES + 1);

  arb_if arb ();

  logic [3:0] priority_select_reg;
  logic tmr1_irq_enable_reg, tmr1_irq_request_reg, tmr1_irq_request_next;
  logic watch_irq_enable_reg, watch_irq_request_reg, watch_irq_request_next;
  logic ctrl_watch_sel_reg;
  logic [2:0] evt_status_reg, evt_status_next, evt_mask_reg;
  logic [WCNT_W-1:0] watch_cnt_reg;
  logic match_prev_reg;
  logic [1:0] holdoff_reg;
  logic wr_phase_reg;
  logic [11:0] wr_idx_reg;
  logic master_irq_enable;
  logic [2:0] prio_code;
  logic access, addr_ok;
  logic [11:0] addr_idx;
  logic wr_prio, wr_watch, wr_tmr1, wr_ctrl, wr_status, wr_mask;
  logic match_now, timer1_match_irq, watch_tick;
  logic [WCNT_W-1:0] watch_limit;
  logic take;
  logic [6:0] pend_all, en_all, svc_mask;
  logic [31:0] read_word;

  // Bus decode on the address phase
  assign access = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  assign addr_ok = (HADDR_IN[31:14] == 18'h00000) && (HADDR_IN[1:0] == 2'h0);
  assign addr_idx = HADDR_IN[13:2];

  // Write strobes in the data phase
  assign wr_prio = wr_phase_reg && (wr_idx_reg == irq_pkg::PRIORITY_IDX);
  assign wr_watch = wr_phase_reg && (wr_idx_reg == irq_pkg::WATCH_FLAGS_IDX);
  assign wr_tmr1 = wr_phase_reg && (wr_idx_reg == irq_pkg::TMR1_FLAGS_IDX);
  assign wr_ctrl = wr_phase_reg && (wr_idx_reg == irq_pkg::CTRL_IDX);
  assign wr_status = wr_phase_reg && (wr_idx_reg == irq_pkg::EVT_STATUS_IDX);
  assign wr_mask = wr_phase_reg && (wr_idx_reg == irq_pkg::EVT_MASK_IDX);

  // Priority register fields
  assign master_irq_enable = priority_select_reg[irq_pkg::MASTER_EN_BIT];
  assign prio_code = priority_select_reg[2:0];

  // Read mux; priority register is write-only and reads zero
  always_comb begin
    read_word = 32'h0000_0000;
    if (addr_ok) begin
      case (addr_idx)
        irq_pkg::WATCH_FLAGS_IDX:
          read_word = {30'h0, watch_irq_enable_reg, watch_irq_request_reg};
        irq_pkg::TMR1_FLAGS_IDX:
          read_word = {30'h0, tmr1_irq_enable_reg, tmr1_irq_request_reg};
        irq_pkg::CTRL_IDX: read_word = {31'h0, ctrl_watch_sel_reg};
        irq_pkg::EVT_STATUS_IDX: read_word = {29'h0, evt_status_reg};
        irq_pkg::EVT_MASK_IDX: read_word = {29'h0, evt_mask_reg};
        irq_pkg::SERVICE_VIEW_IDX:
          read_word = {28'h0, IRQ_SOURCE_OUT, IRQ_REQ_OUT};
        default: read_word = 32'h0000_0000;
      endcase
    end
  end

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      wr_phase_reg <= 1'b0;
      wr_idx_reg <= 12'h000;
      HRDATA_OUT <= 32'h0000_0000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end else begin
      wr_phase_reg <= access && HWRITE_IN && addr_ok;
      wr_idx_reg <= addr_idx;
      if (access && !HWRITE_IN) HRDATA_OUT <= read_word;
    end
  end

  // Match edge of the timer 1 compare, one event per match
  assign match_now = (TIMER1_COUNTER_IN == TIMER1_REFERENCE_IN);
  assign timer1_match_irq = match_now && !match_prev_reg;

  // Watch interval divider; a long count makes a slow enable pulse
  assign watch_limit = ctrl_watch_sel_reg ?
    WCNT_W'(WATCH_SHORT_CYCLES - 1) : WCNT_W'(WATCH_LONG_CYCLES - 1);
  assign watch_tick = (watch_cnt_reg >= watch_limit);

  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN || wr_ctrl || watch_tick) watch_cnt_reg <= '0; // RL3
    else watch_cnt_reg <= watch_cnt_reg + WCNT_W'(1);
  end

  // CPU takes the currently granted source
  assign take = SERVICE_TAKE_IN && IRQ_REQ_OUT;

  // Request flags: hardware set wins over any clear in the same cycle
  always_comb begin
    tmr1_irq_request_next = tmr1_irq_request_reg;
    if (wr_tmr1) tmr1_irq_request_next = HWDATA_IN[irq_pkg::FLAG_REQ_BIT];
    if (take && IRQ_SOURCE_OUT == irq_pkg::SRC_TMR1)
      tmr1_irq_request_next = 1'b0; // RL2
    if (timer1_match_irq) tmr1_irq_request_next = 1'b1; // RL2
    // Watch flag has no hardware clear, only the software write
    watch_irq_request_next = watch_irq_request_reg;
    if (wr_watch)
      watch_irq_request_next = HWDATA_IN[irq_pkg::FLAG_REQ_BIT]; // RL4
    if (watch_tick) watch_irq_request_next = 1'b1; // RL3
  end

  // Flag and control registers
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      priority_select_reg <= irq_pkg::PRIORITY_RESET;
      {tmr1_irq_enable_reg, tmr1_irq_request_reg} <= irq_pkg::FLAGS_RESET[1:0];
      {watch_irq_enable_reg, watch_irq_request_reg} <=
        irq_pkg::FLAGS_RESET[1:0];
      ctrl_watch_sel_reg <= irq_pkg::CTRL_RESET[0];
      match_prev_reg <= 1'b0;
    end else begin
      if (wr_prio) priority_select_reg <= HWDATA_IN[3:0];
      if (wr_tmr1)
        tmr1_irq_enable_reg <= HWDATA_IN[irq_pkg::FLAG_EN_BIT];
      if (wr_watch)
        watch_irq_enable_reg <= HWDATA_IN[irq_pkg::FLAG_EN_BIT];
      if (wr_ctrl)
        ctrl_watch_sel_reg <= HWDATA_IN[irq_pkg::CTRL_WATCH_SEL_BIT];
      tmr1_irq_request_reg <= tmr1_irq_request_next;
      watch_irq_request_reg <= watch_irq_request_next;
      match_prev_reg <= match_now;
    end
  end

  // Event status: sticky, write one to clear, new event beats the clear
  always_comb begin
    evt_status_next = evt_status_reg;
    if (wr_status) evt_status_next = evt_status_reg & ~HWDATA_IN[2:0];
    evt_status_next[irq_pkg::EVT_TMR1_BIT] =
      evt_status_next[irq_pkg::EVT_TMR1_BIT] | timer1_match_irq;
    evt_status_next[irq_pkg::EVT_WATCH_BIT] =
      evt_status_next[irq_pkg::EVT_WATCH_BIT] | watch_tick;
    evt_status_next[irq_pkg::EVT_TAKE_BIT] =
      evt_status_next[irq_pkg::EVT_TAKE_BIT] | take;
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      evt_status_reg <= irq_pkg::EVT_RESET;
      evt_mask_reg <= irq_pkg::EVT_RESET;
      IRQ_OUT <= 1'b0;
    end else begin
      evt_status_reg <= evt_status_next;
      if (wr_mask) evt_mask_reg <= HWDATA_IN[2:0];
      IRQ_OUT <= |(evt_status_next & evt_mask_reg);
    end
  end

  // Pending and enable vectors in rank order; outer sources arrive enabled
  assign pend_all = {watch_irq_request_reg, tmr1_irq_request_reg,
                     TIMER0_MATCH_IRQ_IN, EXT_PIN1_IRQ_IN, EXT_PIN0_IRQ_IN,
                     EXT_PIN4_IRQ_IN, BASIC_TIMER_IRQ_IN};
  assign en_all = {watch_irq_enable_reg, tmr1_irq_enable_reg, 5'h1F}; // RL1

  // Service status qualifies which sources may be served
  assign svc_mask =
    (SERVICE_STATUS_FIELD_IN == irq_pkg::SVC_ALL) ? 7'h7F :
    (SERVICE_STATUS_FIELD_IN == irq_pkg::SVC_FAVOURED) ?
      irq_pkg::favour_mask(prio_code) : 7'h00; // RL12

  // Arbiter inputs; pending requests stay waiting while gated off
  assign arb.pend = pend_all; // RL13
  assign arb.elig = pend_all & en_all & svc_mask &
                    {7{master_irq_enable}}; // RL5
  assign arb.favour = irq_pkg::favour_mask(prio_code); // RL6 RL11
  assign arb.fifo_mode = (prio_code == 3'h0); // RL7

  irq_arbiter u_arbiter (
    .clk (CLOCK_IN),
    .rst (SYS_RST_IN),
    .bus (arb.arb)
  );

  // Grant to the CPU; short holdoff lets a served source drop its level
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      IRQ_REQ_OUT <= 1'b0;
      IRQ_SOURCE_OUT <= 3'h0;
      SOURCE_ACK_OUT <= 7'h00;
      holdoff_reg <= 2'h0;
    end else begin
      SOURCE_ACK_OUT <= take ? (7'h01 << IRQ_SOURCE_OUT) : 7'h00;
      if (take) begin
        IRQ_REQ_OUT <= 1'b0;
        holdoff_reg <= irq_pkg::TAKE_HOLDOFF;
      end else if (holdoff_reg != 2'h0) begin
        IRQ_REQ_OUT <= 1'b0;
        holdoff_reg <= holdoff_reg - 2'h1;
      end else begin
        IRQ_REQ_OUT <= arb.pick_valid; // RL5 RL10
        if (arb.pick_valid) IRQ_SOURCE_OUT <= arb.pick;
      end
    end
  end

  // Timer 1 is granted only if it was enabled
  a_tmr1_gated: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
    (!tmr1_irq_enable_reg && !take && holdoff_reg == 2'h0)
      |=> !(IRQ_REQ_OUT && IRQ_SOURCE_OUT == irq_pkg::SRC_TMR1)) // RL1
    else $error("timer 1 granted while disabled");

  a_tmr1_match_set: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN) // RL2
    timer1_match_irq |=> tmr1_irq_request_reg)
    else $error("timer 1 match did not set its request");

  a_tmr1_take_clear: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN) // RL2
    (take && IRQ_SOURCE_OUT == irq_pkg::SRC_TMR1 && !timer1_match_irq)
      |=> !tmr1_irq_request_reg ##1 SOURCE_ACK_OUT == 7'h00)
    else $error("timer 1 request not cleared on take");

  a_watch_tick_set: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN) // RL3
    watch_tick |=> watch_irq_request_reg && watch_cnt_reg == '0)
    else $error("watch interval did not set its request");

  a_watch_no_hw_clear: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN) // RL4
    (watch_irq_request_reg && !wr_watch) |=> watch_irq_request_reg)
    else $error("watch request cleared without a software write");

  a_master_blocks: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN) // RL5
    !master_irq_enable [*2] |=> !IRQ_REQ_OUT)
    else $error("request granted with master enable low");

  a_favoured_wins: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN) // RL10
    ((arb.elig & arb.favour) != 7'h00 && !take && holdoff_reg == 2'h0)
      |=> IRQ_REQ_OUT &&
          ((($past(arb.favour) >> IRQ_SOURCE_OUT) & 7'h01) != 7'h00))
    else $error("favoured source lost contention");

  a_status_none: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN) // RL12
    (SERVICE_STATUS_FIELD_IN == irq_pkg::SVC_NONE) |=> !IRQ_REQ_OUT)
    else $error("request granted while service status forbids it");

  a_pending_kept: assert property (
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN) // RL13
    (tmr1_irq_request_reg && !tmr1_irq_enable_reg && !wr_tmr1)
      |=> tmr1_irq_request_reg)
    else $error("disabled timer 1 request was lost");

endmodule : irq_flags_priority

// [tb/cpu_partner.sv]
// CPU-side partner: takes granted requests and models level sources
`timescale 1ns/1ps
module cpu_partner (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control from the bench
  input wire logic take_en_in,
  input wire logic [3:0] take_delay_in,
  input wire logic [4:0] raise_in,
  // Service link
  input wire logic irq_req_in,
  input wire logic [6:0] ack_in,
  output logic take_out,
  output logic [4:0] level_out
);
  logic [3:0] wait_reg;

  // Take after a chosen delay; a one-cycle pulse, then wait afresh
  always_ff @(posedge clk_in) begin
    if (rst_in || !irq_req_in || take_out) begin
      wait_reg <= 4'h0;
      take_out <= 1'b0;
    end else if (take_en_in && wait_reg >= take_delay_in) begin
      take_out <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end

  // Sources hold until taken; dropping one cycle after ack keeps the limit
  always_ff @(posedge clk_in) begin
    if (rst_in)
      level_out <= 5'h00;
    else
      level_out <= (level_out & ~ack_in[4:0]) | raise_in;
  end
endmodule : cpu_partner

// [tb/test_interrupt_flags_and_priority.sv]
// Self-checking bench for the interrupt flags and priority block
`timescale 1ns/1ps
module test_interrupt_flags_and_priority;
  localparam int LONG_CYC = 40;
  localparam int SHORT_CYC = 10;
  localparam logic [7:0] REF_VAL = 8'h5A;
  logic clk, rst, hsel, hwrite, hready, hresp, irq_req, irq, take, take_en;
  logic [1:0] htrans, svc;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] cnt;
  logic [2:0] src;
  logic [6:0] ack;
  logic [4:0] raise, level;
  logic [3:0] dly;
  int taken[$];
  int fail_count, comparisons, n;

  // Short watch intervals keep the run brief
  irq_flags_priority #(.WATCH_LONG_CYCLES(LONG_CYC),
    .WATCH_SHORT_CYCLES(SHORT_CYC)) irq_flags_priority_i (
    .CLOCK_IN(clk), .SYS_RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .TIMER1_COUNTER_IN(cnt), .TIMER1_REFERENCE_IN(REF_VAL),
    .BASIC_TIMER_IRQ_IN(level[0]), .EXT_PIN4_IRQ_IN(level[1]),
    .EXT_PIN0_IRQ_IN(level[2]), .EXT_PIN1_IRQ_IN(level[3]),
    .TIMER0_MATCH_IRQ_IN(level[4]), .SERVICE_STATUS_FIELD_IN(svc),
    .SERVICE_TAKE_IN(take), .IRQ_REQ_OUT(irq_req), .IRQ_SOURCE_OUT(src),
    .SOURCE_ACK_OUT(ack), .IRQ_OUT(irq));

  cpu_partner cpu_partner_i (.clk_in(clk), .rst_in(rst),
    .take_en_in(take_en), .take_delay_in(dly), .raise_in(raise),
    .irq_req_in(irq_req), .ack_in(ack), .take_out(take), .level_out(level));

  // Clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Record the order in which sources are taken
  always @(posedge clk) begin
    for (int i = 0; i < 7; i++) begin
      if (ack[i] === 1'b1) taken.push_back(i);
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %0h want %0h", $time, what, seen, exp);
    end
  endtask : check

  // One single AHB transfer; waits on ready, no fixed latency assumed
  task automatic bus(input logic wr, input logic [11:0] idx,
                     input logic [31:0] wdata);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {18'h0, idx, 2'h0};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wdata;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp,
                       input string what);
    bus(1'b0, idx, 32'h0);
    check(rd, exp, what);
  endtask : rdchk

  // Sample point one step past the edge, so updates have landed
  task automatic cycles(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cycles

  task automatic ctl(input logic te, input logic [1:0] s,
                     input logic [3:0] d);
    @(posedge clk);
    take_en <= te;
    svc <= s;
    dly <= d;
  endtask : ctl

  // Raise level sources and optionally one timer 1 match
  task automatic fire(input logic [4:0] m, input logic hit);
    @(posedge clk);
    raise <= m;
    cnt <= hit ? REF_VAL : 8'h00;
    @(posedge clk);
    raise <= 5'h00;
    cnt <= 8'h00;
  endtask : fire

  task automatic wait_acks(input int k);
    for (int i = 0; i < 300 && taken.size() < k; i++) cycles(1);
    check(taken.size(), k, "ack count");
  endtask : wait_acks

  task automatic grant_time(output int t);
    for (t = 0; t < 200 && irq_req !== 1'b1; t++) cycles(1);
  endtask : grant_time

  task automatic t_regs;
    rdchk(irq_pkg::WATCH_FLAGS_IDX, 32'h0, "watch reset");
    rdchk(irq_pkg::TMR1_FLAGS_IDX, 32'h0, "tmr1 reset");
    bus(1'b1, irq_pkg::PRIORITY_IDX, 32'h0000_000F);
    rdchk(irq_pkg::PRIORITY_IDX, 32'h0, "priority write-only");
    bus(1'b1, irq_pkg::TMR1_FLAGS_IDX, 32'hFFFF_FFFE);
    rdchk(irq_pkg::TMR1_FLAGS_IDX, 32'h2, "tmr1 upper bits");
    bus(1'b1, irq_pkg::TMR1_FLAGS_IDX, 32'h0);
    bus(1'b1, 12'hF00, 32'h0000_000F);
    rdchk(12'hF00, 32'h0, "unmapped");
    check(hresp, 1'b0, "okay response");
    $display("t_regs done");
  endtask : t_regs

  task automatic t_tmr1;
    bus(1'b1, irq_pkg::PRIORITY_IDX, 32'h8);
    fire(5'h00, 1'b1);
    cycles(3);
    check(irq_req, 1'b0, "disabled tmr1 passed");
    rdchk(irq_pkg::TMR1_FLAGS_IDX, 32'h1, "match sets flag");
    bus(1'b1, irq_pkg::PRIORITY_IDX, 32'h0);
    bus(1'b1, irq_pkg::TMR1_FLAGS_IDX, 32'h3);
    cycles(3);
    check(irq_req, 1'b0, "master off");
    bus(1'b1, irq_pkg::PRIORITY_IDX, 32'h8);
    cycles(2);
    check(irq_req, 1'b1, "pending raised");
    check(src, 3'h5, "tmr1 source");
    rdchk(irq_pkg::SERVICE_VIEW_IDX, 32'hB, "service view");
    ctl(1'b1, irq_pkg::SVC_ALL, 4'h0);
    wait_acks(1);
    check(taken[0], 5, "tmr1 taken");
    ctl(1'b0, irq_pkg::SVC_ALL, 4'h0);
    rdchk(irq_pkg::TMR1_FLAGS_IDX, 32'h2, "flag auto clear");
    taken.delete();
    $display("t_tmr1 done");
  endtask : t_tmr1

  task automatic t_watch;
    bus(1'b1, irq_pkg::CTRL_IDX, 32'h1);
    bus(1'b1, irq_pkg::WATCH_FLAGS_IDX, 32'h2);
    grant_time(n);
    check(n >= SHORT_CYC - 5 && n <= SHORT_CYC + 1, 1, "short tick");
    check(src, 3'h6, "watch source");
    ctl(1'b1, irq_pkg::SVC_ALL, 4'h3);
    wait_acks(1);
    ctl(1'b0, irq_pkg::SVC_ALL, 4'h0);
    rdchk(irq_pkg::WATCH_FLAGS_IDX, 32'h3, "watch kept");
    bus(1'b1, irq_pkg::WATCH_FLAGS_IDX, 32'h0);
    bus(1'b1, irq_pkg::CTRL_IDX, 32'h0);
    bus(1'b1, irq_pkg::WATCH_FLAGS_IDX, 32'h2);
    grant_time(n);
    check(n >= LONG_CYC - 5 && n <= LONG_CYC + 1, 1, "long tick");
    bus(1'b1, irq_pkg::WATCH_FLAGS_IDX, 32'h0);
    taken.delete();
    $display("t_watch done");
  endtask : t_watch

  task automatic t_order;
    bus(1'b1, irq_pkg::PRIORITY_IDX, 32'h8);
    ctl(1'b0, irq_pkg::SVC_NONE, 4'h0);
    fire(5'h10, 1'b0);
    cycles(2);
    fire(5'h01, 1'b0);
    cycles(3);
    check(irq_req, 1'b0, "status none");
    ctl(1'b1, irq_pkg::SVC_ALL, 4'h6);
    wait_acks(2);
    check(taken[0], 4, "oldest first");
    check(taken[1], 0, "then newer");
    taken.delete();
    ctl(1'b0, irq_pkg::SVC_NONE, 4'h0);
    fire(5'h0C, 1'b0);
    ctl(1'b1, irq_pkg::SVC_ALL, 4'h0);
    wait_acks(2);
    check(taken[0], 2, "tie by rank");
    check(taken[1], 3, "rank order");
    taken.delete();
    bus(1'b1, irq_pkg::PRIORITY_IDX, 32'hC);
    ctl(1'b0, irq_pkg::SVC_NONE, 4'h0);
    fire(5'h10, 1'b0);
    cycles(2);
    fire(5'h01, 1'b0);
    ctl(1'b1, irq_pkg::SVC_ALL, 4'h0);
    wait_acks(2);
    check(taken[0], 0, "code 100 ranks");
    check(taken[1], 4, "code 100 then timer0");
    ctl(1'b0, irq_pkg::SVC_ALL, 4'h0);
    taken.delete();
    $display("t_order done");
  endtask : t_order

  task automatic t_favour;
    logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
    int fav [5] = '{0, 2, 3, 4, 5};
    int k;
    for (int c = 0; c < 5; c++) begin
      taken.delete();
      ctl(1'b0, irq_pkg::SVC_NONE, 4'h0);
      bus(1'b1, irq_pkg::PRIORITY_IDX, {28'h0, 1'b1, codes[c]});
      fire(5'h1F, 1'b1);
      ctl(1'b1, irq_pkg::SVC_ALL, 4'h1);
      wait_acks(6);
      check(taken[0], fav[c], "favoured first");
      k = 1;
      for (int s = 0; s < 6; s++) begin
        if (s != fav[c]) begin
          check(taken[k], s, "rank after favour");
          k++;
        end
      end
    end
    taken.delete();
    bus(1'b1, irq_pkg::PRIORITY_IDX, 32'hD);
    ctl(1'b1, irq_pkg::SVC_FAVOURED, 4'h0);
    fire(5'h14, 1'b0);
    wait_acks(1);
    check(taken[0], 4, "favoured only");
    cycles(10);
    check(taken.size(), 1, "others held");
    ctl(1'b1, irq_pkg::SVC_ALL, 4'h0);
    wait_acks(2);
    check(taken[1], 2, "released by 00");
    ctl(1'b0, irq_pkg::SVC_ALL, 4'h0);
    $display("t_favour done");
  endtask : t_favour

  task automatic t_events;
    bus(1'b1, irq_pkg::TMR1_FLAGS_IDX, 32'h0);
    bus(1'b1, irq_pkg::EVT_MASK_IDX, 32'h1);
    bus(1'b1, irq_pkg::EVT_STATUS_IDX, 32'h7);
    fire(5'h00, 1'b1);
    cycles(3);
    check(irq, 1'b1, "match event");
    rdchk(irq_pkg::TMR1_FLAGS_IDX, 32'h1, "pending disabled");
    bus(1'b1, irq_pkg::EVT_MASK_IDX, 32'h0);
    cycles(2);
    check(irq, 1'b0, "masked");
    bus(1'b1, irq_pkg::EVT_MASK_IDX, 32'h1);
    cycles(2);
    check(irq, 1'b1, "unmasked");
    bus(1'b1, irq_pkg::EVT_STATUS_IDX, 32'h1);
    cycles(2);
    check(irq, 1'b0, "cleared");
    $display("t_events done");
  endtask : t_events

  task automatic finish_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    cnt = 8'h00;
    raise = 5'h00;
    take_en = 1'b0;
    dly = 4'h0;
    svc = irq_pkg::SVC_ALL;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_tmr1();
    t_watch();
    t_order();
    t_favour();
    t_events();
    finish_test();
  end

  // Watchdog well beyond the expected several hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
endmodule : test_interrupt_flags_and_priority
